// ### hdl/assq_map.svh
`ifndef ASSQ_MAP_SVH
`define ASSQ_MAP_SVH
`define ASSQ_ADDR_W 4
`define ASSQ_OFS_SCAN0 4'h0
`define ASSQ_OFS_SEL0 4'h1
`define ASSQ_OFS_SCAN1 4'h2
`define ASSQ_OFS_SEL1 4'h3
`define ASSQ_OFS_INTC0 4'h4
`define ASSQ_OFS_INTC1 4'h5
`define ASSQ_CTRL_RESET 8'h80
`define ASSQ_INTC_RESET 8'hC0
`define ASSQ_BIT_SCAN_RUN 4
`define ASSQ_BIT_EXT_TRIG 5
`define ASSQ_BIT_STOP_CYC 6
`define ASSQ_BIT_SEL_START 4
`define ASSQ_BIT_SCAN_DONE 0
`define ASSQ_BIT_SEL_DONE 1
`define ASSQ_BIT_SCAN_IE 2
`define ASSQ_BIT_SEL_IE 3
`define ASSQ_LAST_CH 4'hB
`endif

// ### hdl/assq_pkg.sv
package assq_pkg;
  typedef enum logic [3:0] {
    ASSQ_IDLE = 4'b0001,
    ASSQ_SCAN = 4'b0010,
    ASSQ_SEL = 4'b0100,
    ASSQ_WAIT = 4'b1000
  } assq_state_t;
endpackage

// ### hdl/assq_sequencer.sv
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "assq_map.svh"

// one converter unit's sequencer
module assq_unit
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [6:0] scan_ctrl_i,
  input wire logic [6:0] sel_ctrl_i,
  input wire logic scan_done_flag_i,
  input wire logic trig_edge_i,
  input wire logic conv_done_i,
  output logic conv_start_o,
  output logic [3:0] conv_channel_o,
  output logic [1:0] conv_time_o,
  output logic scan_cycle_done_o,
  output logic sel_done_o
);
  assq_pkg::assq_state_t state;
  logic [3:0] scan_ch;
  logic run_q;
  logic halted;
  logic need_edge;
  logic scan_go;
  logic sel_go;
  logic run_rise;

  // true on the unit's last channel, where a scan cycle ends
  function automatic logic assq_at_last(input logic [3:0] ch);
    return ch == `ASSQ_LAST_CH;
  endfunction

  assign run_rise = scan_ctrl_i[`ASSQ_BIT_SCAN_RUN] && !run_q;
  assign sel_go = sel_ctrl_i[`ASSQ_BIT_SEL_START];
  assign scan_go = scan_ctrl_i[`ASSQ_BIT_SCAN_RUN] && !halted && !run_rise
    && (!scan_ctrl_i[`ASSQ_BIT_EXT_TRIG] || !need_edge || trig_edge_i);

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      run_q <= 1'b0;
    else
      run_q <= scan_ctrl_i[`ASSQ_BIT_SCAN_RUN];
  end

  // resume on flag or stop clear
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      halted <= 1'b0;
    else if (!scan_ctrl_i[`ASSQ_BIT_SCAN_RUN])
      halted <= 1'b0;
    else if (state == assq_pkg::ASSQ_SCAN && conv_done_i && assq_at_last(scan_ch)
             && scan_ctrl_i[`ASSQ_BIT_STOP_CYC])
      halted <= 1'b1;
    // the flag is still clear in the cycle after the halt, so that cycle must not resume
    else if ((!scan_done_flag_i && !scan_cycle_done_o) || !scan_ctrl_i[`ASSQ_BIT_STOP_CYC])
      halted <= 1'b0;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      need_edge <= 1'b0;
    else if (run_rise)
      need_edge <= 1'b0;
    else if (state == assq_pkg::ASSQ_SCAN && conv_done_i)
      need_edge <= 1'b1;
    else if (state == assq_pkg::ASSQ_IDLE && scan_go && !sel_go)
      need_edge <= 1'b1;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= assq_pkg::ASSQ_IDLE;
      scan_ch <= 4'h0;
      conv_start_o <= 1'b0;
      conv_channel_o <= 4'h0;
      conv_time_o <= 2'b00;
      scan_cycle_done_o <= 1'b0;
      sel_done_o <= 1'b0;
    end
    else
    begin
      conv_start_o <= 1'b0;
      scan_cycle_done_o <= 1'b0;
      sel_done_o <= 1'b0;
      if (run_rise)
        scan_ch <= scan_ctrl_i[3:0];
      unique case (state)
        assq_pkg::ASSQ_IDLE:
        begin
          if (sel_go)
          begin
            state <= assq_pkg::ASSQ_SEL;
            conv_start_o <= 1'b1;
            conv_channel_o <= sel_ctrl_i[3:0];
            conv_time_o <= sel_ctrl_i[6:5];
          end
          else if (scan_go)
          begin
            state <= assq_pkg::ASSQ_SCAN;
            conv_start_o <= 1'b1;
            conv_channel_o <= scan_ch;
            conv_time_o <= sel_ctrl_i[6:5];
          end
        end
        assq_pkg::ASSQ_SCAN:
        begin
          if (sel_go)
          begin
            state <= assq_pkg::ASSQ_SEL;
            conv_start_o <= 1'b1;
            conv_channel_o <= sel_ctrl_i[3:0];
            conv_time_o <= sel_ctrl_i[6:5];
          end
          else if (!scan_ctrl_i[`ASSQ_BIT_SCAN_RUN])
            state <= assq_pkg::ASSQ_WAIT;
          else if (conv_done_i)
          begin
            state <= assq_pkg::ASSQ_IDLE;
            if (assq_at_last(scan_ch))
            begin
              scan_cycle_done_o <= 1'b1;
              scan_ch <= scan_ctrl_i[3:0];
            end
            else
              scan_ch <= scan_ch + 4'h1;
          end
        end
        assq_pkg::ASSQ_SEL:
        begin
          if (conv_done_i)
          begin
            sel_done_o <= 1'b1;
            state <= assq_pkg::ASSQ_WAIT;
          end
        end
        assq_pkg::ASSQ_WAIT:
          state <= assq_pkg::ASSQ_IDLE;
      endcase
    end
  end
endmodule

module assq_sequencer
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [`ASSQ_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic ext_irq_pin_i,
  input wire logic [1:0] conv_done_i,
  output logic [1:0] conv_start_o,
  output logic [7:0] conv_channel_o,
  output logic [3:0] conv_time_o,
  output logic irq_o
);
  logic [6:0] scan_ctrl [2];
  logic [6:0] sel_ctrl [2];
  logic [7:0] intc [2];
  logic [1:0] pin_sync;
  logic pin_prev;
  logic trig_edge;
  logic [1:0] cyc_done;
  logic [1:0] sel_done;
  logic [3:0] ch_raw [2];
  logic [1:0] tm_raw [2];

  // register index decode, shared by both units
  function automatic logic assq_hit(input logic [`ASSQ_ADDR_W-1:0] addr, input logic unit,
    input logic [`ASSQ_ADDR_W-1:0] ofs0, input logic [`ASSQ_ADDR_W-1:0] ofs1);
    return addr == (unit ? ofs1 : ofs0);
  endfunction

  // one unit's request: a set flag together with its enable
  function automatic logic assq_unit_irq(input logic [7:0] ic);
    return (ic[`ASSQ_BIT_SCAN_DONE] && ic[`ASSQ_BIT_SCAN_IE])
      || (ic[`ASSQ_BIT_SEL_DONE] && ic[`ASSQ_BIT_SEL_IE]);
  endfunction

  // control registers carry a constant one in bit 7
  function automatic logic [7:0] assq_ctrl_rd(input logic [6:0] r);
    return {1'b1, r};
  endfunction

  // pin through two flops, then rising-edge detect
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_sync <= 2'b00;
      pin_prev <= 1'b0;
    end
    else
    begin
      pin_sync <= {pin_sync[0], ext_irq_pin_i};
      pin_prev <= pin_sync[1];
    end
  end
  assign trig_edge = pin_sync[1] && !pin_prev;

  genvar u;
  generate
    for (u = 0; u < 2; u++)
    begin : g_unit
      assq_unit unit_i (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .scan_ctrl_i(scan_ctrl[u]),
        .sel_ctrl_i(sel_ctrl[u]),
        .scan_done_flag_i(intc[u][`ASSQ_BIT_SCAN_DONE]),
        .trig_edge_i(trig_edge),
        .conv_done_i(conv_done_i[u]),
        .conv_start_o(conv_start_o[u]),
        .conv_channel_o(ch_raw[u]),
        .conv_time_o(tm_raw[u]),
        .scan_cycle_done_o(cyc_done[u]),
        .sel_done_o(sel_done[u])
      );

      assign conv_time_o[u*2 +: 2] = tm_raw[u];

      always_ff @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          scan_ctrl[u] <= 7'h00;
        else if (reg_wr_i && assq_hit(reg_addr_i, (u == 1), `ASSQ_OFS_SCAN0, `ASSQ_OFS_SCAN1))
        begin
          if (!scan_ctrl[u][`ASSQ_BIT_SCAN_RUN])
            scan_ctrl[u][3:0] <= reg_wdata_i[3:0];
          scan_ctrl[u][6:4] <= reg_wdata_i[6:4];
        end
      end

      always_ff @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          sel_ctrl[u] <= 7'h00;
        else if (reg_wr_i && assq_hit(reg_addr_i, (u == 1), `ASSQ_OFS_SEL0, `ASSQ_OFS_SEL1))
        begin
          if (!sel_ctrl[u][`ASSQ_BIT_SEL_START])
            sel_ctrl[u][3:0] <= reg_wdata_i[3:0];
          sel_ctrl[u][6:4] <= reg_wdata_i[6:4];
        end
        else if (sel_done[u])
          sel_ctrl[u][`ASSQ_BIT_SEL_START] <= 1'b0;
      end

      // interrupt control reset; flags set win over clear
      always_ff @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          intc[u] <= `ASSQ_INTC_RESET;
        else
        begin
          if (reg_wr_i && assq_hit(reg_addr_i, (u == 1), `ASSQ_OFS_INTC0, `ASSQ_OFS_INTC1))
          begin
            // flags clear by writing one
            if (reg_wdata_i[`ASSQ_BIT_SCAN_DONE])
              intc[u][`ASSQ_BIT_SCAN_DONE] <= 1'b0;
            if (reg_wdata_i[`ASSQ_BIT_SEL_DONE])
              intc[u][`ASSQ_BIT_SEL_DONE] <= 1'b0;
            if (reg_wdata_i[4])
              intc[u][4] <= 1'b0;
            // enables are only ever set by writing one
            if (reg_wdata_i[`ASSQ_BIT_SCAN_IE])
              intc[u][`ASSQ_BIT_SCAN_IE] <= 1'b1;
            if (reg_wdata_i[`ASSQ_BIT_SEL_IE])
              intc[u][`ASSQ_BIT_SEL_IE] <= 1'b1;
            if (reg_wdata_i[5])
              intc[u][5] <= 1'b1;
          end
          if (cyc_done[u])
            intc[u][`ASSQ_BIT_SCAN_DONE] <= 1'b1;
          if (sel_done[u])
            intc[u][`ASSQ_BIT_SEL_DONE] <= 1'b1;
        end
      end
    end
  endgenerate

  // unit 1 channels are numbered 12 up; each nibble is the unit's local index
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      conv_channel_o <= 8'h00;
    else
      conv_channel_o <= {ch_raw[1], ch_raw[0]};
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= assq_unit_irq(intc[0]) || assq_unit_irq(intc[1]);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      unique case (reg_addr_i)
        `ASSQ_OFS_SCAN0: reg_rdata_o <= assq_ctrl_rd(scan_ctrl[0]);
        `ASSQ_OFS_SEL0: reg_rdata_o <= assq_ctrl_rd(sel_ctrl[0]);
        `ASSQ_OFS_SCAN1: reg_rdata_o <= assq_ctrl_rd(scan_ctrl[1]);
        `ASSQ_OFS_SEL1: reg_rdata_o <= assq_ctrl_rd(sel_ctrl[1]);
        `ASSQ_OFS_INTC0: reg_rdata_o <= intc[0];
        `ASSQ_OFS_INTC1: reg_rdata_o <= intc[1];
        default: reg_rdata_o <= 8'h00;
      endcase
    else
      reg_rdata_o <= 8'h00;
  end
endmodule
`default_nettype wire

// ### sim/assq_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module assq_core_model #(parameter int DLY = 6)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] start_i,
  output logic [1:0] done_o
);
  int cnt [2];
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      done_o <= 2'b00;
      cnt <= '{0, 0};
    end
    else
    begin
      for (int u = 0; u < 2; u++)
      begin
        done_o[u] <= (cnt[u] == 1);
        if (start_i[u])
          cnt[u] <= DLY;
        else if (cnt[u] > 0)
          cnt[u] <= cnt[u] - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/assq_sequencer_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "assq_map.svh"
module assq_sequencer_checker
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [`ASSQ_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [1:0] conv_start_o,
  input wire logic [7:0] conv_channel_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  idle_rdata_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read");
  ctrl_top_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) < 4'h4 |-> reg_rdata_o[7])
    else $error("control bit 7 read as zero");
  intc_top_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) inside {4'h4, 4'h5}
    |-> reg_rdata_o[7:6] == 2'b11)
    else $error("interrupt control top bits wrong");
  unmapped_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) > 4'h5 |-> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  pulse_zero_a: assert property (conv_start_o[0] |=> !conv_start_o[0])
    else $error("unit0 start longer than one cycle");
  pulse_one_a: assert property (conv_start_o[1] |=> !conv_start_o[1])
    else $error("unit1 start longer than one cycle");
  chan_zero_a: assert property (conv_start_o[0] |=> conv_channel_o[3:0] <= 4'hB)
    else $error("unit0 channel past last");
  chan_one_a: assert property (conv_start_o[1] |=> conv_channel_o[7:4] <= 4'hB)
    else $error("unit1 channel past last");
endmodule
bind assq_sequencer assq_sequencer_checker chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o));
`default_nettype wire

// ### sim/assq_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "assq_map.svh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module assq_sequencer_tb;
  logic sys_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, ext_irq_pin_i = 0, irq_o;
  logic [3:0] reg_addr_i = 0, conv_time_o;
  logic [7:0] reg_wdata_i = 0, reg_rdata_o, conv_channel_o, d;
  logic [1:0] conv_done_i, conv_start_o, st_d = 0;
  logic [3:0] q0 [$], q1 [$];
  logic [1:0] t0;
  int mismatches = 0, comparisons = 0;
  assq_sequencer dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .ext_irq_pin_i(ext_irq_pin_i), .conv_done_i(conv_done_i), .conv_start_o(conv_start_o),
    .conv_channel_o(conv_channel_o), .conv_time_o(conv_time_o), .irq_o(irq_o));
  assq_core_model core (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .start_i(conv_start_o),
    .done_o(conv_done_i));
  initial forever #10 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    st_d <= conv_start_o;
    if (conv_start_o[0]) t0 <= conv_time_o[1:0];
    if (st_d[0]) q0.push_back(conv_channel_o[3:0]);
    if (st_d[1]) q1.push_back(conv_channel_o[7:4]);
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1;
    @(posedge sys_clk_i);
    reg_wr_i <= 0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1;
    @(posedge sys_clk_i);
    reg_rd_i <= 0;
    #1 d = reg_rdata_o;
  endtask
  task automatic waitn(input int u, input int n);
    for (int i = 0; i < 500 && (u ? q1.size() : q0.size()) < n; i++) @(posedge sys_clk_i);
    repeat (12) @(posedge sys_clk_i);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    mismatches++;
    conclude();
  end
  initial
  begin
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1;
    for (int a = 0; a < 6; a++)
    begin
      rd(a[3:0]);
      `CHK("reset value", (a < 4) ? 8'h80 : 8'hC0, d)
    end
    rd(4'hF);
    `CHK("unmapped", 8'h00, d)
    // unit0 scan from 9, halt after last channel
    wr(`ASSQ_OFS_SCAN0, 8'h59);
    waitn(0, 3);
    `CHK("scan order", {4'h9, 4'hA, 4'hB}, {q0[0], q0[1], q0[2]})
    rd(`ASSQ_OFS_INTC0);
    `CHK("scan flag", 1'b1, d[0])
    wr(`ASSQ_OFS_SCAN0, 8'h52);
    waitn(0, 4);
    `CHK("no rerun", 3, q0.size())
    rd(`ASSQ_OFS_SCAN0);
    `CHK("scan reg", 8'hD9, d)
    wr(`ASSQ_OFS_INTC0, 8'h01);
    waitn(0, 6);
    `CHK("restart", 4'h9, q0[3])
    wr(`ASSQ_OFS_SCAN0, 8'h00);
    // select channel 5 with time 2
    wr(`ASSQ_OFS_SEL0, 8'h55);
    waitn(0, 7);
    `CHK("sel chan", 4'h5, q0[6])
    `CHK("sel time", 2'b10, t0)
    rd(`ASSQ_OFS_SEL0);
    `CHK("sel clear", 8'hC5, d)
    `CHK("irq masked", 1'b0, irq_o)
    wr(`ASSQ_OFS_INTC0, 8'h08);
    repeat (3) @(posedge sys_clk_i);
    `CHK("irq on", 1'b1, irq_o)
    wr(`ASSQ_OFS_INTC0, 8'h02);
    repeat (3) @(posedge sys_clk_i);
    `CHK("irq off", 1'b0, irq_o)
    // unit1 external trigger from 10
    wr(`ASSQ_OFS_SCAN1, 8'h7A);
    waitn(1, 1);
    `CHK("ext first", 4'hA, q1[0])
    waitn(1, 2);
    `CHK("ext wait", 1, q1.size())
    // pin taken as in its alternate function; rising edge triggers
    ext_irq_pin_i <= 1;
    repeat (4) @(posedge sys_clk_i);
    ext_irq_pin_i <= 0;
    waitn(1, 2);
    `CHK("ext next", 4'hB, q1[1])
    rd(`ASSQ_OFS_INTC1);
    `CHK("unit1 flag", 1'b1, d[0])
    wr(`ASSQ_OFS_SCAN1, 8'h40);
    wr(`ASSQ_OFS_SCAN1, 8'h73);
    waitn(1, 3);
    `CHK("ext rerun", 4'h3, q1[2])
    `CHK("ext hold", 3, q1.size())
    conclude();
  end
endmodule
`default_nettype wire
